// *** verilog/dds_defs.svh ***
/*
  constants for the dual converter serial load logic: word layout, preset codes,
  serial clock timing and decode values.
  assumes: included by bare name from the package and from both ends.
*/
`ifndef DDS_DEFS_SVH
`define DDS_DEFS_SVH

`define DDS_WORD_W 16
`define DDS_CODE_W 14
`define DDS_SEL_HI_BIT 15
`define DDS_SEL_LO_BIT 14
`define DDS_CODE_MSB 13
`define DDS_WORD_MSB 15
`define DDS_NEXT_BIT 14
`define DDS_LAST_BIT 4'hF

`define DDS_ZERO_CODE 14'h0000
`define DDS_MID_CODE 14'h2000
`define DDS_WORD_RESET 16'h0000

`define DDS_SEL_NONE 2'h0
`define DDS_SEL_A 2'h1
`define DDS_SEL_B 2'h2
`define DDS_SEL_BOTH 2'h3

`define DDS_REG_WORD 2'h0
`define DDS_REG_CTRL 2'h1
`define DDS_REG_STAT 2'h2
`define DDS_CTRL_LOAD 0
`define DDS_CTRL_PRESET 1
`define DDS_CTRL_MID 2
`define DDS_STAT_BUSY 0
`define DDS_RD_ZERO 16'h0000

`define DDS_CORE_PERIOD_NS 8
`define DDS_SCLK_PERIOD_NS 64
`define DDS_HALF_CYC (`DDS_SCLK_PERIOD_NS / 2 / `DDS_CORE_PERIOD_NS)
`define DDS_GAP_CYC 4'h8
`define DDS_POR_CYC 2'h3

`endif

// *** verilog/dds_pkg.sv ***
/*
  types shared by both ends of the serial load link.
  assumes: dds_defs.svh on the include path.
*/
`default_nettype none
`include "dds_defs.svh"

package dds_pkg;

  typedef logic [`DDS_CODE_W-1:0] dds_code_t;
  typedef logic [`DDS_WORD_W-1:0] dds_word_t;

  typedef enum logic [2:0] {
    DDS_IDLE,
    DDS_LOW,
    DDS_HIGH,
    DDS_HOLD,
    DDS_GAP
  } dds_host_state_t;

endpackage : dds_pkg

`default_nettype wire

// *** verilog/dds_link_if.sv ***
/*
  link between the serial master and the converter control logic.
  assumes: the host drives every wire; the device only listens.
*/
`timescale 1ns/1ps
`default_nettype none

interface dds_link_if;
  logic sclk;
  logic cs_n;
  logic serial_data_in;
  logic dac_load_strobe_n;
  logic preset_n;
  logic midscale_sel;

  modport host (
    output sclk,
    output cs_n,
    output serial_data_in,
    output dac_load_strobe_n,
    output preset_n,
    output midscale_sel
  );

  modport dev (
    input sclk,
    input cs_n,
    input serial_data_in,
    input dac_load_strobe_n,
    input preset_n,
    input midscale_sel
  );
endinterface : dds_link_if

`default_nettype wire

// *** verilog/dds_dev.sv ***
/*
  device end: serial shift register on the link clock, input and converter
  registers for two channels on core_clk, preset and power-on handling.
  assumes: host keeps cs_n high for several core_clk cycles after each word,
  so the shift register is quiet while core_clk picks it up.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dds_defs.svh"

module dds_chan (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic force_en,
  input wire dds_pkg::dds_code_t force_code,
  input wire logic load,
  input wire dds_pkg::dds_code_t load_code,
  input wire logic xfer,
  output dds_pkg::dds_code_t input_code,
  output dds_pkg::dds_code_t dac_code
);

  dds_pkg::dds_code_t next_input;
  dds_pkg::dds_code_t next_dac;

  // preset is checked first so a load in the same cycle cannot slip past it
  assign next_input = force_en ? force_code : (load ? load_code : input_code);
  assign next_dac = force_en ? force_code : (xfer ? input_code : dac_code);

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      input_code <= `DDS_ZERO_CODE;
      dac_code <= `DDS_ZERO_CODE;
    end
    else
    begin
      input_code <= next_input;
      dac_code <= next_dac;
    end
  end

endmodule : dds_chan

module dds_dev (
  input wire logic core_clk,
  input wire logic resetn,
  dds_link_if.dev link,
  output dds_pkg::dds_code_t input_a_code,
  output dds_pkg::dds_code_t input_b_code,
  output dds_pkg::dds_code_t dac_a_code,
  output dds_pkg::dds_code_t dac_b_code,
  output logic load_seen
);

  // link clock domain

  dds_pkg::dds_word_t shift_word;

  always_ff @(posedge link.sclk or negedge resetn)
  begin
    if (!resetn)
    begin
      shift_word <= `DDS_WORD_RESET;
    end
    else if (!link.cs_n)
    begin
      // a plain 16 bit shifter keeps only the newest bits of a long frame
      shift_word <= {shift_word[`DDS_NEXT_BIT:0], link.serial_data_in};
    end
  end

  // core clock domain: pin synchronisers

  logic cs_meta;
  logic cs_sync;
  logic cs_prev;
  logic strobe_meta;
  logic strobe_sync;
  logic preset_meta;
  logic preset_sync;
  logic strap_meta;
  logic strap_sync;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
      strobe_meta <= 1'b1;
      strobe_sync <= 1'b1;
      preset_meta <= 1'b1;
      preset_sync <= 1'b1;
      strap_meta <= 1'b0;
      strap_sync <= 1'b0;
    end
    else
    begin
      cs_meta <= link.cs_n;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
      strobe_meta <= link.dac_load_strobe_n;
      strobe_sync <= strobe_meta;
      preset_meta <= link.preset_n;
      preset_sync <= preset_meta;
      strap_meta <= link.midscale_sel;
      strap_sync <= strap_meta;
    end
  end

  // power-on hold: forces preset long enough for the strap to reach strap_sync

  logic [1:0] por_cnt;
  logic por_active;

  assign por_active = (por_cnt != `DDS_POR_CYC);

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      por_cnt <= 2'h0;
    end
    else if (por_active)
    begin
      por_cnt <= por_cnt + 2'h1;
    end
  end

  // decode and load

  logic cs_rise;
  logic sel_hi;
  logic sel_lo;
  logic load_a;
  logic load_b;
  logic force_en;
  logic xfer;
  dds_pkg::dds_code_t word_code;
  dds_pkg::dds_code_t force_code;

  // the shift word is only read on the synchronised release, when the link clock
  // is parked and cs_n high has frozen the shifter, so the word is stable
  assign cs_rise = cs_sync & ~cs_prev;
  assign sel_hi = shift_word[`DDS_SEL_HI_BIT];
  assign sel_lo = shift_word[`DDS_SEL_LO_BIT];
  assign word_code = shift_word[`DDS_CODE_MSB:0];
  assign load_a = cs_rise & ({sel_hi, sel_lo} == `DDS_SEL_A || {sel_hi, sel_lo} == `DDS_SEL_BOTH);
  assign load_b = cs_rise & ({sel_hi, sel_lo} == `DDS_SEL_B || {sel_hi, sel_lo} == `DDS_SEL_BOTH);
  assign force_en = por_active | ~preset_sync;
  assign force_code = strap_sync ? `DDS_MID_CODE : `DDS_ZERO_CODE;
  assign xfer = ~strobe_sync;

  dds_chan chan_a (
    .core_clk(core_clk),
    .resetn(resetn),
    .force_en(force_en),
    .force_code(force_code),
    .load(load_a),
    .load_code(word_code),
    .xfer(xfer),
    .input_code(input_a_code),
    .dac_code(dac_a_code)
  );

  dds_chan chan_b (
    .core_clk(core_clk),
    .resetn(resetn),
    .force_en(force_en),
    .force_code(force_code),
    .load(load_b),
    .load_code(word_code),
    .xfer(xfer),
    .input_code(input_b_code),
    .dac_code(dac_b_code)
  );

  // one-cycle marker of each accepted release, for the user side
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      load_seen <= 1'b0;
    end
    else
    begin
      load_seen <= cs_rise & ~force_en;
    end
  end

endmodule : dds_dev

`default_nettype wire

// *** verilog/dds_host.sv ***
/*
  host end: serial master that sends one 16 bit word per write to its word
  register made while not busy, with the link clock divided down from core_clk, plus control and
  status registers for strobe, preset, strap and busy, on a classic Wishbone slave.
  assumes: a classic single-cycle master with 16 bit data; word register at 0,
  control at 1, status at 2; the word register reads back as zero.
*/
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "dds_defs.svh"

module dds_host (
  input wire logic core_clk,
  input wire logic resetn,
  dds_link_if.host link,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [1:0] wb_adr_i,
  input wire dds_pkg::dds_word_t wb_dat_i,
  input wire logic [1:0] wb_sel_i,
  output dds_pkg::dds_word_t wb_dat_o,
  output logic wb_ack_o
);

  dds_pkg::dds_host_state_t state;
  dds_pkg::dds_word_t shreg;
  dds_pkg::dds_word_t ctrl_view;
  dds_pkg::dds_word_t stat_view;
  dds_pkg::dds_word_t rd_mux;
  logic [2:0] div;
  logic [3:0] bit_cnt;
  logic [3:0] gap_cnt;
  logic cmd_ready;
  logic half_done;
  logic take;
  logic bus_req;
  logic wr_fire;
  logic wr_word;
  logic wr_ctrl;

  assign half_done = (div == 3'(`DDS_HALF_CYC - 1));
  assign bus_req = wb_cyc_i & wb_stb_i;
  // a write lands at the edge where the master sees ack; partial writes are ignored
  assign wr_fire = bus_req & wb_we_i & wb_ack_o & (&wb_sel_i);
  assign wr_word = wr_fire & (wb_adr_i == `DDS_REG_WORD);
  assign wr_ctrl = wr_fire & (wb_adr_i == `DDS_REG_CTRL);
  // a word written while a frame runs is dropped, so software polls busy first
  assign take = wr_word & cmd_ready;
  assign rd_mux = (wb_adr_i == `DDS_REG_CTRL) ? ctrl_view : ((wb_adr_i == `DDS_REG_STAT) ? stat_view : `DDS_RD_ZERO);

  always_comb
  begin
    ctrl_view = `DDS_RD_ZERO;
    ctrl_view[`DDS_CTRL_LOAD] = ~link.dac_load_strobe_n;
    ctrl_view[`DDS_CTRL_PRESET] = ~link.preset_n;
    ctrl_view[`DDS_CTRL_MID] = link.midscale_sel;
    stat_view = `DDS_RD_ZERO;
    stat_view[`DDS_STAT_BUSY] = ~cmd_ready;
  end

  // one wait state; ack falls the cycle after it was given
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `DDS_RD_ZERO;
    end
    else
    begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      if (bus_req & ~wb_we_i & ~wb_ack_o)
      begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  // the control register is the pin flops themselves, so no extra latency
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      link.dac_load_strobe_n <= 1'b1;
      link.preset_n <= 1'b1;
      link.midscale_sel <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      link.dac_load_strobe_n <= ~wb_dat_i[`DDS_CTRL_LOAD];
      link.preset_n <= ~wb_dat_i[`DDS_CTRL_PRESET];
      link.midscale_sel <= wb_dat_i[`DDS_CTRL_MID];
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= dds_pkg::DDS_IDLE;
      link.sclk <= 1'b0;
      link.cs_n <= 1'b1;
      link.serial_data_in <= 1'b0;
      cmd_ready <= 1'b1;
      shreg <= `DDS_WORD_RESET;
      div <= 3'h0;
      bit_cnt <= 4'h0;
      gap_cnt <= 4'h0;
    end
    else
    begin
      case (state)
        dds_pkg::DDS_IDLE:
        begin
          if (take)
          begin
            shreg <= wb_dat_i;
            link.serial_data_in <= wb_dat_i[`DDS_WORD_MSB];
            link.cs_n <= 1'b0;
            cmd_ready <= 1'b0;
            div <= 3'h0;
            bit_cnt <= 4'h0;
            state <= dds_pkg::DDS_LOW;
          end
        end
        dds_pkg::DDS_LOW:
        begin
          div <= half_done ? 3'h0 : div + 3'h1;
          if (half_done)
          begin
            link.sclk <= 1'b1;
            state <= dds_pkg::DDS_HIGH;
          end
        end
        dds_pkg::DDS_HIGH:
        begin
          div <= half_done ? 3'h0 : div + 3'h1;
          if (half_done)
          begin
            link.sclk <= 1'b0;
            if (bit_cnt == `DDS_LAST_BIT)
            begin
              state <= dds_pkg::DDS_HOLD;
            end
            else
            begin
              // cs_n stays low for the whole word, byte boundaries included
              bit_cnt <= bit_cnt + 4'h1;
              shreg <= {shreg[`DDS_NEXT_BIT:0], 1'b0};
              link.serial_data_in <= shreg[`DDS_NEXT_BIT];
              state <= dds_pkg::DDS_LOW;
            end
          end
        end
        dds_pkg::DDS_HOLD:
        begin
          div <= half_done ? 3'h0 : div + 3'h1;
          if (half_done)
          begin
            link.cs_n <= 1'b1;
            gap_cnt <= 4'h0;
            state <= dds_pkg::DDS_GAP;
          end
        end
        dds_pkg::DDS_GAP:
        begin
          // the gap lets the device fetch the word before any new shifting
          gap_cnt <= gap_cnt + 4'h1;
          if (gap_cnt == `DDS_GAP_CYC - 4'h1)
          begin
            cmd_ready <= 1'b1;
            state <= dds_pkg::DDS_IDLE;
          end
        end
        default:
        begin
          state <= dds_pkg::DDS_IDLE;
        end
      endcase
    end
  end

endmodule : dds_host

`default_nettype wire

// *** verif/dds_link_asserts.sv ***
/*
  checker for the serial link and the converter codes.
  assumes: every link wire comes from core_clk flops, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dds_defs.svh"

module dds_link_asserts (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_data_in,
  input wire logic dac_load_strobe_n,
  input wire logic preset_n,
  input wire logic midscale_sel,
  input wire dds_pkg::dds_code_t input_a_code,
  input wire dds_pkg::dds_code_t input_b_code,
  input wire dds_pkg::dds_code_t dac_a_code,
  input wire dds_pkg::dds_code_t dac_b_code,
  input wire logic load_seen
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  wire dds_pkg::dds_code_t preset_code = midscale_sel ? `DDS_MID_CODE : `DDS_ZERO_CODE;

  // five samples cover the two sync flops plus the register edge
  sequence s_preset_low;
    (!preset_n && $stable(midscale_sel)) [*5];
  endsequence
  sequence s_strobe_open;
    (!dac_load_strobe_n && $stable(input_a_code) && $stable(input_b_code)) [*5];
  endsequence
  sequence s_strobe_shut;
    (dac_load_strobe_n && preset_n) [*5];
  endsequence

  property p_sclk_idle;
    cs_n |-> !sclk;
  endproperty
  property p_cs_rise;
    $rose(cs_n) |-> !sclk && !$past(sclk);
  endproperty
  property p_sdi_hold;
    sclk |-> $stable(serial_data_in);
  endproperty
  property p_frame;
    $fell(cs_n) |-> ##132 $rose(cs_n);
  endproperty
  property p_preset;
    s_preset_low |-> input_a_code == preset_code && input_b_code == preset_code
      && dac_a_code == preset_code && dac_b_code == preset_code;
  endproperty
  property p_hold;
    s_strobe_shut |-> $stable(dac_a_code) && $stable(dac_b_code);
  endproperty
  property p_follow;
    s_strobe_open |-> dac_a_code == input_a_code && dac_b_code == input_b_code;
  endproperty
  property p_load;
    $rose(cs_n) && preset_n |-> ##[2:7] load_seen;
  endproperty

  a_sclk_idle: assert property (p_sclk_idle) else $error("sclk moves outside a frame");
  a_cs_rise: assert property (p_cs_rise) else $error("cs_n rose with sclk high");
  a_sdi_hold: assert property (p_sdi_hold) else $error("sdi moved while sclk high");
  a_frame: assert property (p_frame) else $error("frame length wrong");
  a_preset: assert property (p_preset) else $error("preset value not forced");
  a_hold: assert property (p_hold) else $error("dac codes moved while strobe high");
  a_follow: assert property (p_follow) else $error("dac codes do not follow inputs");
  a_load: assert property (p_load) else $error("no load after cs_n rise");
endmodule : dds_link_asserts

`default_nettype wire

// *** verif/tb.sv ***
/*
  self-checking bench: host and device joined by the link interface.
  assumes: no clock but core_clk; the host makes the link clock itself.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic core_clk = 1'b0;
  logic resetn;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [1:0] wb_adr = 2'h0;
  dds_pkg::dds_word_t wb_dat_w = 16'h0000;
  logic [1:0] wb_sel = 2'h0;
  dds_pkg::dds_word_t wb_dat_r;
  logic wb_ack;
  logic [2:0] ctrl = 3'h0;
  logic load_seen;
  dds_pkg::dds_code_t input_a_code, input_b_code, dac_a_code, dac_b_code;
  dds_pkg::dds_code_t ea = 14'h0000, eb = 14'h0000, da = 14'h0000, db = 14'h0000;
  logic [27:0] expq[$];
  logic [27:0] cur;
  logic [31:0] seed = 32'h2BFB;
  int err_total = 0;
  int total_checks = 0;

  dds_link_if link ();
  dds_host u_dds_host (.core_clk, .resetn, .link(link.host), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat_w), .wb_sel_i(wb_sel), .wb_dat_o(wb_dat_r),
    .wb_ack_o(wb_ack));
  dds_dev u_dds_dev (.core_clk, .resetn, .link(link.dev), .input_a_code, .input_b_code,
    .dac_a_code, .dac_b_code, .load_seen);
  dds_link_asserts u_dds_link_asserts (.core_clk, .resetn, .sclk(link.sclk), .cs_n(link.cs_n),
    .serial_data_in(link.serial_data_in), .dac_load_strobe_n(link.dac_load_strobe_n), .preset_n(link.preset_n),
    .midscale_sel(link.midscale_sel), .input_a_code, .input_b_code, .dac_a_code, .dac_b_code,
    .load_seen);

  always #4 core_clk = ~core_clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic chk(input string what, input dds_pkg::dds_code_t exp, input dds_pkg::dds_code_t got);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic check_all();
    chk("input_a", ea, input_a_code);
    chk("input_b", eb, input_b_code);
    chk("dac_a", da, dac_a_code);
    chk("dac_b", db, dac_b_code);
  endtask : check_all

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // classic single cycle: request held until ack is seen, data taken there, then a free cycle
  task automatic wb_cycle(input logic we, input logic [1:0] a, input dds_pkg::dds_word_t d,
    output dds_pkg::dds_word_t q);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    wb_sel <= 2'h3;
    do @(posedge core_clk); while (wb_ack !== 1'b1);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge core_clk);
  endtask : wb_cycle

  task automatic wait_idle();
    dds_pkg::dds_word_t st;
    st = 16'h0001;
    while (st[0] !== 1'b0)
      wb_cycle(1'b0, 2'h2, 16'h0000, st);
  endtask : wait_idle

  // bit 0 load strobe, bit 1 preset, bit 2 midscale strap; read back after writing
  task automatic set_ctrl(input logic [2:0] c);
    dds_pkg::dds_word_t q;
    ctrl = c;
    wb_cycle(1'b1, 2'h1, {13'h0000, c}, q);
    wb_cycle(1'b0, 2'h1, 16'h0000, q);
    chk("ctrl", {11'h000, c}, q[13:0]);
  endtask : set_ctrl

  // one word per write; the input register expectation is queued for the monitor
  task automatic send(input dds_pkg::dds_word_t w);
    dds_pkg::dds_word_t q;
    wait_idle();
    wb_cycle(1'b1, 2'h0, w, q);
    if (w[14]) ea = w[13:0];
    if (w[15]) eb = w[13:0];
    expq.push_back({ea, eb});
    wait_idle();
    repeat (4) @(posedge core_clk);
    if (ctrl[0])
    begin
      da = ea;
      db = eb;
    end
    chk("dac_a", da, dac_a_code);
    chk("dac_b", db, dac_b_code);
  endtask : send

  task automatic preset(input logic m);
    set_ctrl({m, 1'b1, ctrl[0]});
    repeat (8) @(posedge core_clk);
    ea = m ? 14'h2000 : 14'h0000;
    eb = ea;
    da = ea;
    db = ea;
    check_all();
    set_ctrl({m, 1'b0, ctrl[0]});
    repeat (8) @(posedge core_clk);
  endtask : preset

  // results show as a load_seen pulse; the oldest note is compared then
  always @(posedge core_clk)
    if (load_seen === 1'b1)
    begin
      cur = (expq.size() != 0) ? expq.pop_front() : 28'hFFFFFFF;
      chk("input_a", cur[27:14], input_a_code);
      chk("input_b", cur[13:0], input_b_code);
    end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    close_out();
  end

  initial
  begin
    // an x to 0 step gives the asynchronous resets a real falling edge at time zero
    resetn <= 1'b0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (8) @(posedge core_clk);
    check_all();
    for (int k = 0; k < 8; k++)
    begin
      seed = xs(seed);
      if (k == 4)
      begin
        set_ctrl(3'h1);
        repeat (6) @(posedge core_clk);
        da = ea;
        db = eb;
        check_all();
      end
      send({2'(k), (k == 3) ? 14'h3FFF : seed[13:0]});
    end
    preset(1'b1);
    set_ctrl(3'h4);
    repeat (6) @(posedge core_clk);
    send({2'h3, seed[17:4]});
    preset(1'b0);
    close_out();
  end
endmodule : tb

`default_nettype wire
